// [vcx_pkg.sv]
// Constants, register map and carrier types for the video crosspoint control logic.
package vcx_pkg;

   // ==========================================================================
   // Two-wire bus addressing
   // ==========================================================================
   localparam logic [7:0] VCX_DEV_ADDR_LO = 8'h84;
   localparam logic [7:0] VCX_DEV_ADDR_HI = 8'h8c;
   localparam logic [3:0] VCX_BITS_BYTE   = 4'h8;

   // ==========================================================================
   // Register offsets and storage indices
   // ==========================================================================
   localparam logic [7:0] VCX_OFS_COMP_SEL  = 8'h00;
   localparam logic [7:0] VCX_OFS_SVID_SEL  = 8'h01;
   localparam logic [7:0] VCX_OFS_CMPT_SEL  = 8'h02;
   localparam logic [7:0] VCX_OFS_CLMP_MODE = 8'h03;
   localparam logic [7:0] VCX_OFS_FILTER    = 8'h04;
   localparam logic [7:0] VCX_OFS_SEP_A     = 8'h05;
   localparam logic [7:0] VCX_OFS_SEP_B     = 8'h06;
   localparam logic [7:0] VCX_OFS_MISC2     = 8'h16;

   localparam int         VCX_NREG          = 8;
   localparam logic [2:0] VCX_IDX_COMP_SEL  = 3'h0;
   localparam logic [2:0] VCX_IDX_SVID_SEL  = 3'h1;
   localparam logic [2:0] VCX_IDX_CMPT_SEL  = 3'h2;
   localparam logic [2:0] VCX_IDX_CLMP_MODE = 3'h3;
   localparam logic [2:0] VCX_IDX_FILTER    = 3'h4;
   localparam logic [2:0] VCX_IDX_SEP_A     = 3'h5;
   localparam logic [2:0] VCX_IDX_SEP_B     = 3'h6;
   localparam logic [2:0] VCX_IDX_MISC2     = 3'h7;

   localparam logic [7:0] VCX_REG_RESET     = 8'h00;

   // ==========================================================================
   // Field layout: groups A and B share a register, one nibble each
   // ==========================================================================
   localparam int VCX_NIB_A      = 0;
   localparam int VCX_NIB_B      = 4;
   localparam int VCX_SLAVE_BIT  = 0;
   localparam int VCX_FCOMP_BIT  = 0;
   localparam int VCX_FSVID_BIT  = 1;
   localparam int VCX_FCMPT_LSB  = 2;
   // Clamp-disable register: group A in the high nibble, group B in the low one.
   localparam int VCX_MISC_A     = 4;
   localparam int VCX_MISC_B     = 0;
   localparam int VCX_DIS_COMP   = 0;
   localparam int VCX_DIS_SVID   = 1;
   localparam int VCX_DIS_CMPT   = 2;
   localparam int VCX_LOW_OFS    = 3;

   localparam logic [2:0] VCX_COMP_SRCS = 3'h6;
   localparam logic [7:0] VCX_SEP_SVID_OFF = 8'h25;
   localparam logic [7:0] VCX_SEP_CMPT_OFF = 8'h24;

   // Component filter codes.
   localparam logic [1:0] VCX_CFLT_BYPASS = 2'h0;
   localparam logic [1:0] VCX_CFLT_10MHZ  = 2'h1;
   localparam logic [1:0] VCX_CFLT_20MHZ  = 2'h2;
   localparam logic [1:0] VCX_CFLT_36MHZ  = 2'h3;

   // ==========================================================================
   // Carrier types
   // ==========================================================================
   typedef struct packed {
      logic [5:0] comp_sel;        // One-hot composite source.
      logic [3:0] svid_sel;        // One-hot S-video source (Y and C together).
      logic [3:0] cmpt_sel;        // One-hot component source (three together).
      logic       slave_mode;      // 1 = clamp timed by the group's sync separator.
      logic       tip_clamp;       // Sync-tip clamp on luma and composite.
      logic       keyed_to_luma;   // Chroma keyed clamp timed to luma.
      logic [7:0] sep_cfg;         // Sync separator source setting.
      logic       comp_filt_en;    // Composite 7 MHz low-pass, else bypass.
      logic       svid_filt_en;    // S-video 10 MHz filter, else bypass.
      logic [1:0] cmpt_filt;       // Component filter code.
      logic       comp_clamp_en;
      logic       svid_pulldn_en;  // Luma and chroma pull-down.
      logic       svid_y_pullup_en;
      logic       svid_c_pullup_en;
      logic       cmpt_pulldn_en;  // All three components.
      logic       cmpt_y_pullup_en;
      logic       cmpt_cd_pullup_en;
      logic       cmpt_low_ofs;
   } vcx_grp_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] ofs;
      logic [7:0] data;
   } vcx_wr_t;

endpackage

// [vcx_serial_slave.sv]
// Two-wire bus slave engine: address match, register offset, data bytes, acknowledge.
`timescale 1ns/1ps
module vcx_serial_slave
   import vcx_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic       addr_sel_i,
   input  wire logic [7:0] rd_data_i,
   output logic      [7:0] rd_ofs_o,
   output vcx_wr_t         wr_o,
   output logic            sda_oe_n_o
);

   typedef enum logic [4:0] {
      VCX_S_IDLE = 5'b00001,
      VCX_S_ADDR = 5'b00010,
      VCX_S_WRB  = 5'b00100,
      VCX_S_ACKT = 5'b01000,
      VCX_S_RDB  = 5'b10000
   } vcx_st_t;

   // ==========================================================================
   // Synchronisers: the first stage feeds only the second
   // ==========================================================================
   logic [2:0] scl_sy_ff;
   logic [2:0] sda_sy_ff;
   logic [1:0] asel_sy_ff;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_sy_ff  <= 3'h7;
         sda_sy_ff  <= 3'h7;
         asel_sy_ff <= 2'h0;
      end else begin
         scl_sy_ff  <= {scl_sy_ff[1:0], scl_i};
         sda_sy_ff  <= {sda_sy_ff[1:0], sda_i};
         asel_sy_ff <= {asel_sy_ff[0], addr_sel_i};
      end
   end

   wire scl_s    = scl_sy_ff[1];
   wire sda_s    = sda_sy_ff[1];
   wire scl_rise = scl_sy_ff[1] & ~scl_sy_ff[2];
   wire scl_fall = ~scl_sy_ff[1] & scl_sy_ff[2];
   wire start_ev = scl_s & scl_sy_ff[2] & ~sda_s & sda_sy_ff[2];
   wire stop_ev  = scl_s & scl_sy_ff[2] & sda_s & ~sda_sy_ff[2];

   // ==========================================================================
   // Byte engine
   // ==========================================================================
   vcx_st_t    st_ff;
   logic [7:0] sh_ff;
   logic [3:0] cnt_ff;
   logic       rw_ff;
   logic       first_ff;
   logic       nack_ff;
   logic       rd_ack_ff;
   logic [7:0] ofs_ff;
   vcx_wr_t    wr_ff;
   logic       oe_n_ff;

   wire [7:0] my_addr  = asel_sy_ff[1] ? VCX_DEV_ADDR_HI : VCX_DEV_ADDR_LO;
   wire       addr_hit = (sh_ff[7:1] == my_addr[7:1]);
   wire       byte_end = (cnt_ff == VCX_BITS_BYTE);

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_ff     <= VCX_S_IDLE;
         sh_ff     <= 8'h00;
         cnt_ff    <= 4'h0;
         rw_ff     <= 1'b0;
         first_ff  <= 1'b0;
         nack_ff   <= 1'b0;
         rd_ack_ff <= 1'b0;
         ofs_ff    <= 8'h00;
         wr_ff     <= '0;
         oe_n_ff   <= 1'b1;
      end else begin
         wr_ff.wr <= 1'b0;
         if (start_ev) begin
            st_ff    <= VCX_S_ADDR;
            cnt_ff   <= 4'h0;
            first_ff <= 1'b1;
            oe_n_ff  <= 1'b1;
         end else if (stop_ev) begin
            st_ff   <= VCX_S_IDLE;
            oe_n_ff <= 1'b1;
         end else begin
            unique case (st_ff)
               VCX_S_IDLE: begin
                  oe_n_ff <= 1'b1;
               end
               VCX_S_ADDR, VCX_S_WRB: begin
                  if (scl_rise && !byte_end) begin
                     sh_ff  <= {sh_ff[6:0], sda_s};
                     cnt_ff <= cnt_ff + 4'h1;
                  end else if (scl_fall && byte_end) begin
                     cnt_ff <= 4'h0;
                     if (st_ff == VCX_S_ADDR) begin
                        if (addr_hit) begin
                           st_ff   <= VCX_S_ACKT;
                           oe_n_ff <= 1'b0;
                           rw_ff   <= sh_ff[0];
                        end else begin
                           st_ff <= VCX_S_IDLE;
                        end
                     end else begin
                        st_ff    <= VCX_S_ACKT;
                        oe_n_ff  <= 1'b0;
                        first_ff <= 1'b0;
                        if (first_ff) begin
                           ofs_ff <= sh_ff;
                        end else begin
                           wr_ff <= '{wr: 1'b1, ofs: ofs_ff, data: sh_ff};
                           ofs_ff <= ofs_ff + 8'h01;
                        end
                     end
                  end
               end
               VCX_S_ACKT: begin
                  if (scl_fall) begin
                     cnt_ff <= 4'h0;
                     if (rw_ff) begin
                        st_ff   <= VCX_S_RDB;
                        sh_ff   <= rd_data_i;
                        oe_n_ff <= rd_data_i[7];
                        ofs_ff  <= ofs_ff + 8'h01;
                     end else begin
                        st_ff   <= VCX_S_WRB;
                        oe_n_ff <= 1'b1;
                     end
                  end
               end
               VCX_S_RDB: begin
                  if (scl_rise) begin
                     cnt_ff <= cnt_ff + 4'h1;
                     if (byte_end) begin
                        nack_ff <= sda_s;
                     end
                  end else if (scl_fall) begin
                     if (cnt_ff == VCX_BITS_BYTE) begin
                        oe_n_ff   <= 1'b1;
                        rd_ack_ff <= 1'b1;
                     end else if (byte_end || rd_ack_ff) begin
                        rd_ack_ff <= 1'b0;
                        cnt_ff    <= 4'h0;
                        if (nack_ff) begin
                           st_ff <= VCX_S_IDLE;
                        end else begin
                           sh_ff   <= rd_data_i;
                           oe_n_ff <= rd_data_i[7];
                           ofs_ff  <= ofs_ff + 8'h01;
                        end
                     end else begin
                        sh_ff   <= {sh_ff[6:0], 1'b0};
                        oe_n_ff <= sh_ff[6];
                     end
                  end
               end
            endcase
         end
      end
   end

   assign rd_ofs_o   = ofs_ff;
   assign wr_o       = wr_ff;
   assign sda_oe_n_o = oe_n_ff;

endmodule

// [vcx_crosspoint_ctrl.sv]
// Top of the video crosspoint control logic: register bank, selectors, clamps, power-down.
//
// Contract
// - Answer bus address 0x84 with select pin low or open, 0x8C when high.
// - Reset low then high clears every data register to 0x00.
// - Power-down high disables analog circuitry and tri-states all video outputs.
// - In power-down the serial interface stays active and registers keep contents.
// - Composite selector gives outputs A and B each one of six sources.
// - S-video and component selectors switch together; each output picks one of four.
// - Sources reach only outputs of their own signal type.
// - Groups A and B each have an independent master or slave clamp setting.
// - Master mode uses internal sync; tip clamp luma, chroma keyed to luma.
// - Slave mode clamps from the group separator, fed by external or video sync.
// - Composite outputs choose 7 MHz low-pass filter or bypass.
// - S-video outputs choose 10 MHz filter or bypass.
// - Component outputs choose 36, 20 or 10 MHz filter, or bypass.
// - A one in a clamp-disable bit at offset 0x16 disables that clamp.
// - S-video disable kills pull-downs and luma pull-up; chroma pull-up needs 0x25.
// - Component disable kills pull-downs and luma pull-up; colour pull-ups need 0x24.
// - Bit 7 enables component low-offset clamp for A, bit 3 for B.
`timescale 1ns/1ps
module vcx_crosspoint_ctrl
   import vcx_pkg::*;
(
   input  wire logic  ref_clk_i,
   input  wire logic  resetn_i,
   input  wire logic  scl_i,
   input  wire logic  sda_i,
   output logic       sda_o,
   output logic       sda_oe_n_o,
   input  wire logic  addr_sel_i,
   input  wire logic  low_power_input_i,
   output logic       analog_en_o,
   output logic       video_hiz_o,
   output vcx_grp_t   grp_a_o,
   output vcx_grp_t   grp_b_o
);

   // ==========================================================================
   // Decoding helpers
   // ==========================================================================
   function automatic logic [3:0] reg_index(input logic [7:0] ofs, output logic hit);
      begin
         hit       = 1'b1;
         reg_index = {1'b0, VCX_IDX_COMP_SEL};
         case (ofs)
            VCX_OFS_COMP_SEL:  reg_index = {1'b0, VCX_IDX_COMP_SEL};
            VCX_OFS_SVID_SEL:  reg_index = {1'b0, VCX_IDX_SVID_SEL};
            VCX_OFS_CMPT_SEL:  reg_index = {1'b0, VCX_IDX_CMPT_SEL};
            VCX_OFS_CLMP_MODE: reg_index = {1'b0, VCX_IDX_CLMP_MODE};
            VCX_OFS_FILTER:    reg_index = {1'b0, VCX_IDX_FILTER};
            VCX_OFS_SEP_A:     reg_index = {1'b0, VCX_IDX_SEP_A};
            VCX_OFS_SEP_B:     reg_index = {1'b0, VCX_IDX_SEP_B};
            VCX_OFS_MISC2:     reg_index = {1'b0, VCX_IDX_MISC2};
            default:           hit = 1'b0;
         endcase
      end
   endfunction

   // Composite codes 6 and 7 name no source, so the output selects nothing.
   function automatic logic [5:0] comp_onehot(input logic [2:0] code);
      begin
         comp_onehot = (code < VCX_COMP_SRCS) ? 6'(6'h01 << code) : 6'h00;
      end
   endfunction

   function automatic logic [3:0] quad_onehot(input logic [1:0] code);
      begin
         quad_onehot = 4'(4'h1 << code);
      end
   endfunction

   // ==========================================================================
   // Serial slave and register bank
   // ==========================================================================
   vcx_wr_t    wr;
   logic [7:0] rd_ofs;
   logic [7:0] rd_data;
   logic [7:0] regs_ff [VCX_NREG];
   logic       wr_hit;
   logic       rd_hit;
   logic [3:0] wr_idx;
   logic [3:0] rd_idx;

   // The engine never looks at the power-down level, so it keeps serving the
   // host while the analog side sleeps.
   vcx_serial_slave u_slave (
      .ref_clk_i  (ref_clk_i),
      .resetn_i   (resetn_i),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .addr_sel_i (addr_sel_i),
      .rd_data_i  (rd_data),
      .rd_ofs_o   (rd_ofs),
      .wr_o       (wr),
      .sda_oe_n_o (sda_oe_n_o)
   );

   always_comb begin
      wr_idx = reg_index(wr.ofs, wr_hit);
      rd_idx = reg_index(rd_ofs, rd_hit);
   end

   // Unmapped offsets read as zero and ignore writes.
   assign rd_data = rd_hit ? regs_ff[rd_idx[2:0]] : 8'h00;

   genvar r;
   generate
      for (r = 0; r < VCX_NREG; r++) begin : g_reg
         always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               regs_ff[r] <= VCX_REG_RESET;
            end else if (wr.wr && wr_hit && (wr_idx == 4'(r))) begin
               regs_ff[r] <= wr.data;
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Power-down pin synchroniser and outputs
   // ==========================================================================
   logic [1:0] pd_sy_ff;
   logic       analog_en_ff;
   logic       hiz_ff;
   logic       sda_ff;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pd_sy_ff     <= 2'h0;
         analog_en_ff <= 1'b0;
         hiz_ff       <= 1'b1;
         sda_ff       <= 1'b0;
      end else begin
         pd_sy_ff     <= {pd_sy_ff[0], low_power_input_i};
         analog_en_ff <= ~pd_sy_ff[1];
         hiz_ff       <= pd_sy_ff[1];
         sda_ff       <= 1'b0;
      end
   end

   assign analog_en_o = analog_en_ff;
   assign video_hiz_o = hiz_ff;
   assign sda_o       = sda_ff;

   // ==========================================================================
   // Per-group selector, clamp and filter control
   // ==========================================================================
   vcx_grp_t nxt_grp [2];
   vcx_grp_t grp_ff  [2];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_grp
         localparam int NIB = (g == 0) ? VCX_NIB_A : VCX_NIB_B;
         localparam int MSC = (g == 0) ? VCX_MISC_A : VCX_MISC_B;
         localparam logic [2:0] SEP_IDX = (g == 0) ? VCX_IDX_SEP_A : VCX_IDX_SEP_B;

         wire [7:0] sel_c   = regs_ff[VCX_IDX_COMP_SEL];
         wire [7:0] sel_s   = regs_ff[VCX_IDX_SVID_SEL];
         wire [7:0] sel_k   = regs_ff[VCX_IDX_CMPT_SEL];
         wire [7:0] mode    = regs_ff[VCX_IDX_CLMP_MODE];
         wire [7:0] filt    = regs_ff[VCX_IDX_FILTER];
         wire [7:0] misc    = regs_ff[VCX_IDX_MISC2];
         wire [7:0] sep     = regs_ff[SEP_IDX];
         wire       slave   = mode[NIB + VCX_SLAVE_BIT];
         wire       dis_c   = misc[MSC + VCX_DIS_COMP];
         wire       dis_s   = misc[MSC + VCX_DIS_SVID];
         wire       dis_k   = misc[MSC + VCX_DIS_CMPT];
         wire       s_c_off = dis_s && (sep == VCX_SEP_SVID_OFF);
         wire       k_cd_off = dis_k && (sep == VCX_SEP_CMPT_OFF);

         // Each signal type has its own selector field and its own output
         // bus, so no code can steer one type onto another type's output.
         always_comb begin
            nxt_grp[g].comp_sel          = comp_onehot(sel_c[NIB +: 3]);
            nxt_grp[g].svid_sel          = quad_onehot(sel_s[NIB +: 2]);
            nxt_grp[g].cmpt_sel          = quad_onehot(sel_k[NIB +: 2]);
            nxt_grp[g].slave_mode        = slave;
            nxt_grp[g].tip_clamp         = ~slave;
            nxt_grp[g].keyed_to_luma     = ~slave;
            nxt_grp[g].sep_cfg           = sep;
            nxt_grp[g].comp_filt_en      = filt[NIB + VCX_FCOMP_BIT];
            nxt_grp[g].svid_filt_en      = filt[NIB + VCX_FSVID_BIT];
            nxt_grp[g].cmpt_filt         = filt[NIB + VCX_FCMPT_LSB +: 2];
            nxt_grp[g].comp_clamp_en     = ~dis_c;
            nxt_grp[g].svid_pulldn_en    = ~dis_s;
            nxt_grp[g].svid_y_pullup_en  = ~dis_s;
            nxt_grp[g].svid_c_pullup_en  = ~s_c_off;
            nxt_grp[g].cmpt_pulldn_en    = ~dis_k;
            nxt_grp[g].cmpt_y_pullup_en  = ~dis_k;
            nxt_grp[g].cmpt_cd_pullup_en = ~k_cd_off;
            nxt_grp[g].cmpt_low_ofs      = misc[MSC + VCX_LOW_OFS];
         end

         always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               grp_ff[g] <= '0;
            end else begin
               grp_ff[g] <= nxt_grp[g];
            end
         end
      end
   endgenerate

   assign grp_a_o = grp_ff[0];
   assign grp_b_o = grp_ff[1];

endmodule

// [vcx_host_model.sv]
// Two-wire bus host model that drives the clock and data lines of the crosspoint.
`timescale 1ns/1ps
module vcx_host_model (
   input  wire logic sda_oe_n_i,
   input  wire logic ref_clk_i,
   output logic      scl_o,
   output logic      sda_o
);
   logic drv_low;
   // The data line has a pull-up: it reads high unless some party pulls it low.
   assign sda_o = ~drv_low & sda_oe_n_i;
   initial begin
      scl_o = 1'b1;
      drv_low = 1'b0;
   end
   // Eight clocks per phase keeps both bus phases well above the four-clock minimum.
   task automatic half();
      repeat (8) @(negedge ref_clk_i);
   endtask
   task automatic start();
      drv_low = 1'b0;
      half();
      scl_o = 1'b1;
      half();
      drv_low = 1'b1;
      half();
      scl_o = 1'b0;
   endtask
   task automatic stop();
      drv_low = 1'b1;
      half();
      scl_o = 1'b1;
      half();
      drv_low = 1'b0;
      half();
   endtask
   task automatic bit_tx(input logic b, output logic r);
      drv_low = ~b;
      half();
      scl_o = 1'b1;
      half();
      r = sda_o;
      scl_o = 1'b0;
   endtask
   // Bytes go most significant bit first; mack low releases the line for the device's acknowledge.
   task automatic byte_xfer(input logic [7:0] d, input logic mack, output logic [7:0] rd, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_tx(d[i], rd[i]);
      bit_tx(~mack, a);
      ack = ~a;
   endtask
endmodule

// [vcx_ctrl_sva.sv]
// Port assertions for the crosspoint control top.
`timescale 1ns/1ps
module vcx_ctrl_sva
   import vcx_pkg::*;
(
   input wire logic     ref_clk_i,
   input wire logic     resetn_i,
   input wire logic     sda_o,
   input wire logic     low_power_input_i,
   input wire logic     analog_en_o,
   input wire logic     video_hiz_o,
   input wire vcx_grp_t grp_a_o,
   input wire vcx_grp_t grp_b_o
);
   // Group outputs show the decode only from the first edge after reset, so checks wait one edge.
   logic up_ff;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) up_ff <= 1'b0;
      else up_ff <= 1'b1;
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   AST_PD_ON: assert property ($rose(low_power_input_i) |-> ##[2:3] !analog_en_o && video_hiz_o)
      else $error("power-down not applied");
   AST_PD_OFF: assert property ($fell(low_power_input_i) |-> ##[2:3] analog_en_o && !video_hiz_o)
      else $error("wake from power-down late");
   AST_PD_HOLD: assert property (low_power_input_i [*4] |-> video_hiz_o && !analog_en_o)
      else $error("outputs left on in power-down");
   AST_SDA_OD: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   AST_SEL_HOT: assert property (up_ff |-> $onehot0(grp_a_o.comp_sel) && $onehot(grp_b_o.svid_sel)
      && $onehot(grp_a_o.cmpt_sel) && $onehot0(grp_b_o.comp_sel) && $onehot(grp_a_o.svid_sel)
      && $onehot(grp_b_o.cmpt_sel)) else $error("selector not one-hot");
   AST_MASTER: assert property (up_ff && !grp_a_o.slave_mode |-> grp_a_o.tip_clamp && grp_a_o.keyed_to_luma)
      else $error("master clamp wrong");
   AST_C_PU: assert property (up_ff && !grp_a_o.svid_c_pullup_en |-> !grp_a_o.svid_pulldn_en
      && grp_a_o.sep_cfg == VCX_SEP_SVID_OFF) else $error("chroma pull-up off wrongly");
   AST_CD_PU: assert property (up_ff && !grp_b_o.cmpt_cd_pullup_en |-> !grp_b_o.cmpt_pulldn_en
      && grp_b_o.sep_cfg == VCX_SEP_CMPT_OFF) else $error("colour pull-up off wrongly");
   AST_Y_PU: assert property (grp_a_o.svid_y_pullup_en == grp_a_o.svid_pulldn_en
      && grp_b_o.cmpt_y_pullup_en == grp_b_o.cmpt_pulldn_en) else $error("luma pull-up mismatch");
   cover property (grp_a_o.cmpt_low_ofs && grp_b_o.cmpt_low_ofs);
   cover property ($rose(low_power_input_i));
   cover property (up_ff && !grp_b_o.cmpt_cd_pullup_en);
endmodule
bind vcx_crosspoint_ctrl vcx_ctrl_sva vcx_ctrl_sva_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sda_o(sda_o),
   .low_power_input_i(low_power_input_i), .analog_en_o(analog_en_o), .video_hiz_o(video_hiz_o),
   .grp_a_o(grp_a_o), .grp_b_o(grp_b_o));

// [tb_top.sv]
// Self-checking bench for the crosspoint control logic.
`timescale 1ns/1ps
module tb_top;
   import vcx_pkg::*;
   logic ref_clk = 1'b0, resetn = 1'b0, addr_sel = 1'b0, low_pwr = 1'b0, scl, sda, sda_oe_n, an_en, hiz, ok;
   vcx_grp_t ga, gb;
   logic [7:0] sh [8], dev, d;
   int err_count = 0, n_compared = 0;
   always #25 ref_clk = ~ref_clk;
   vcx_host_model vcx_host_model_i (.sda_oe_n_i(sda_oe_n), .ref_clk_i(ref_clk), .scl_o(scl), .sda_o(sda));
   vcx_crosspoint_ctrl vcx_crosspoint_ctrl_i (.ref_clk_i(ref_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda),
      .sda_o(), .sda_oe_n_o(sda_oe_n), .addr_sel_i(addr_sel), .low_power_input_i(low_pwr), .analog_en_o(an_en),
      .video_hiz_o(hiz), .grp_a_o(ga), .grp_b_o(gb));
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmpg(input vcx_grp_t got, input vcx_grp_t exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Expected group controls from the shadow registers; n is the group's nibble, A 0 and B 4.
   function automatic vcx_grp_t exp_grp(input int n);
      vcx_grp_t g;
      int m;
      logic [2:0] s;
      m = 4 - n;
      s = sh[0][n+:3];
      g.comp_sel = (s < VCX_COMP_SRCS) ? 6'h01 << s : 6'h00;
      g.svid_sel = 4'h1 << sh[1][n+:2];
      g.cmpt_sel = 4'h1 << sh[2][n+:2];
      g.slave_mode = sh[3][n];
      g.tip_clamp = ~sh[3][n];
      g.keyed_to_luma = ~sh[3][n];
      g.sep_cfg = sh[5 + n / 4];
      g.comp_filt_en = sh[4][n];
      g.svid_filt_en = sh[4][n+1];
      g.cmpt_filt = sh[4][n+2+:2];
      g.comp_clamp_en = ~sh[7][m];
      g.svid_pulldn_en = ~sh[7][m+1];
      g.svid_y_pullup_en = ~sh[7][m+1];
      g.svid_c_pullup_en = ~(sh[7][m+1] && g.sep_cfg == 8'h25);
      g.cmpt_pulldn_en = ~sh[7][m+2];
      g.cmpt_y_pullup_en = ~sh[7][m+2];
      g.cmpt_cd_pullup_en = ~(sh[7][m+2] && g.sep_cfg == 8'h24);
      g.cmpt_low_ofs = sh[7][m+3];
      return g;
   endfunction
   task automatic chk_all();
      repeat (4) @(negedge ref_clk);
      cmpg(ga, exp_grp(0));
      cmpg(gb, exp_grp(4));
   endtask
   task automatic raw_wr(input logic [7:0] a, input logic [7:0] o, input logic [7:0] v, output logic k);
      logic [7:0] rd;
      logic a0, a1, a2;
      vcx_host_model_i.start();
      vcx_host_model_i.byte_xfer(a, 1'b0, rd, a0);
      vcx_host_model_i.byte_xfer(o, 1'b0, rd, a1);
      vcx_host_model_i.byte_xfer(v, 1'b0, rd, a2);
      vcx_host_model_i.stop();
      k = a0 & a1 & a2;
   endtask
   task automatic wr(input logic [7:0] o, input logic [7:0] v);
      raw_wr(dev, o, v, ok);
      cmp8({7'h00, ok}, 8'h01);
      if (o < 8'h07) sh[o[2:0]] = v;
      else if (o == VCX_OFS_MISC2) sh[7] = v;
      chk_all();
   endtask
   task automatic rd(input logic [7:0] o, output logic [7:0] v);
      logic [7:0] x;
      logic a;
      vcx_host_model_i.start();
      vcx_host_model_i.byte_xfer(dev, 1'b0, x, a);
      vcx_host_model_i.byte_xfer(o, 1'b0, x, a);
      vcx_host_model_i.start();
      vcx_host_model_i.byte_xfer(dev | 8'h01, 1'b0, x, a);
      vcx_host_model_i.byte_xfer(8'hff, 1'b0, v, a);
      vcx_host_model_i.stop();
   endtask
   initial begin
      repeat (100000) @(posedge ref_clk);
      err_count++;
      conclude();
   end
   initial begin
      sh = '{default: 8'h00};
      dev = VCX_DEV_ADDR_LO;
      void'($urandom(32'hdd6b));
      repeat (4) @(negedge ref_clk);
      resetn = 1'b1;
      chk_all();
      rd(VCX_OFS_MISC2, d);
      cmp8(d, 8'h00);
      wr(VCX_OFS_SEP_A, 8'h25);
      wr(VCX_OFS_SEP_B, 8'h24);
      wr(VCX_OFS_MISC2, 8'hff);
      wr(VCX_OFS_SEP_A, 8'h24);
      wr(VCX_OFS_SEP_B, 8'h25);
      for (int k = 0; k < 8; k++) begin
         wr(VCX_OFS_COMP_SEL, {1'b0, 3'(k), 1'b0, 3'(7 - k)});
         wr(VCX_OFS_FILTER, {4{2'(k)}});
      end
      for (int i = 0; i < 24; i++)
         wr(($urandom % 8 == 7) ? VCX_OFS_MISC2 : 8'($urandom % 7), 8'($urandom));
      rd(VCX_OFS_MISC2, d);
      cmp8(d, sh[7]);
      wr(8'h10, 8'h5a);
      rd(8'h10, d);
      cmp8(d, 8'h00);
      addr_sel = 1'b1;
      raw_wr(VCX_DEV_ADDR_LO, VCX_OFS_CLMP_MODE, 8'h11, ok);
      cmp8({7'h00, ok}, 8'h00);
      dev = VCX_DEV_ADDR_HI;
      wr(VCX_OFS_CLMP_MODE, 8'h10);
      low_pwr = 1'b1;
      repeat (6) @(negedge ref_clk);
      cmp8({6'h00, an_en, hiz}, 8'h01);
      wr(VCX_OFS_SVID_SEL, 8'h32);
      rd(VCX_OFS_SVID_SEL, d);
      cmp8(d, 8'h32);
      low_pwr = 1'b0;
      repeat (6) @(negedge ref_clk);
      cmp8({6'h00, an_en, hiz}, 8'h02);
      resetn = 1'b0;
      repeat (2) @(negedge ref_clk);
      resetn = 1'b1;
      sh = '{default: 8'h00};
      chk_all();
      conclude();
   end
endmodule
